//--- sac_regs.svh
// constants for the conversion control block
`ifndef SAC_REGS_SVH
`define SAC_REGS_SVH
`define SAC_RES_W        10
`define SAC_PRESC_W      8
`define SAC_CYC_NORMAL   5'd13
`define SAC_CYC_FIRST    5'd25
`define SAC_TS_FREE      3'h0
`define SAC_CH_W         4
`define SAC_CH_GND       4'hf
`define SAC_CH_BANDGAP   4'he
`define SAC_REF_W        2
`endif

//--- sac_pkg.sv
// types for the conversion control block
package sac_pkg;
  typedef struct packed {
    logic       converter_enable;
    logic       auto_trigger_enable;
    logic [2:0] trigger_source_select;
    logic       left_adjust_select;
    logic [1:0] reference_select;
    logic [3:0] input_channel_select;
    logic [7:0] prescale_div;
  } sac_cfg_t;
  typedef struct packed {
    logic [7:0] result_high_byte;
    logic [7:0] result_low_byte;
  } sac_result_t;
  typedef enum logic [2:0] {
    SAC_IDLE = 3'b001,
    SAC_WAIT = 3'b010,
    SAC_CONV = 3'b100
  } sac_state_t;
endpackage : sac_pkg

//--- sac_conv_ctrl.sv
// conversion control for a 10-bit successive-approximation converter
`timescale 1ns/10ps
`default_nettype none
`include "sac_regs.svh"
module sac_conv_ctrl
  import sac_pkg::*;
(
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire sac_pkg::sac_cfg_t       cfg,
  input  wire logic                    converter_power_reduction,
  input  wire logic                    start_write,
  input  wire logic                    done_flag_clear,
  input  wire logic                    low_byte_read,
  input  wire logic                    high_byte_read,
  input  wire logic [7:0]              trigger_lines,
  input  wire logic [9:0]              core_sample,
  output logic                         start_conversion_bit,
  output logic                         conversion_done_flag,
  output logic                         conversion_done_pulse,
  output sac_pkg::sac_result_t         result,
  output logic [3:0]                   active_channel,
  output logic [1:0]                   active_reference,
  output logic                         sample_strobe
);
  import sac_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  sac_state_t                state;
  sac_state_t                next_state;
  logic [7:0]                presc;
  logic [4:0]                cyc;
  logic                      first_pending;
  logic                      trig_prev;
  logic                      locked;
  logic                      en_prev;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire powered     = cfg.converter_enable & ~converter_power_reduction;
  wire presc_tick  = powered & (presc >= cfg.prescale_div);
  wire trig_sel    = trigger_lines[cfg.trigger_source_select];
  // free running restarts on finish itself, not on the sticky flag, so clearing it is irrelevant
  wire free_run    = cfg.auto_trigger_enable &
                     (cfg.trigger_source_select == `SAC_TS_FREE);
  wire trig_edge   = powered & cfg.auto_trigger_enable & ~free_run &
                     trig_sel & ~trig_prev;
  wire busy        = (state != SAC_IDLE);
  wire sw_start    = powered & start_write & ~busy;
  wire trig_start  = trig_edge & ~busy;
  wire [4:0] cyc_len = first_pending ? `SAC_CYC_FIRST : `SAC_CYC_NORMAL;
  wire finish      = (state == SAC_CONV) & presc_tick & (cyc == cyc_len - 5'd1);
  wire restart     = finish & free_run;
  wire [15:0] adj_word = cfg.left_adjust_select ?
                         {core_sample, 6'h00} : {6'h00, core_sample};

  always_comb begin
    next_state = state;
    case (state)
      SAC_IDLE: begin
        if (trig_start)
          next_state = SAC_CONV;
        else if (sw_start)
          next_state = SAC_WAIT;
      end
      SAC_WAIT: begin
        // software start begins on the next converter clock edge
        if (!powered)
          next_state = SAC_IDLE;
        else if (presc_tick)
          next_state = SAC_CONV;
      end
      SAC_CONV: begin
        if (!powered)
          next_state = SAC_IDLE;
        else if (finish && !restart)
          next_state = SAC_IDLE;
      end
      default: next_state = SAC_IDLE;
    endcase
  end

  // ------------------------------------------------------------
  // prescaler and cycle count
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !powered || trig_start)
      presc <= 8'h00;
    else if (presc_tick)
      presc <= 8'h00;
    else
      presc <= presc + 8'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || state != SAC_CONV || finish)
      cyc <= 5'h00;
    else if (presc_tick)
      cyc <= cyc + 5'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state   <= SAC_IDLE;
      en_prev <= 1'b0;
    end else begin
      state   <= next_state;
      en_prev <= powered;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      first_pending <= 1'b1;
    else if (powered && !en_prev)
      first_pending <= 1'b1;
    else if (finish)
      first_pending <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      trig_prev <= 1'b0;
    else
      trig_prev <= trig_sel;
  end

  // ------------------------------------------------------------
  // selection latch, result and flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      active_channel   <= 4'h0;
      active_reference <= 2'h0;
    end else if (powered && (state != SAC_CONV || finish)) begin
      active_channel   <= cfg.input_channel_select;
      active_reference <= cfg.reference_select;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      locked <= 1'b0;
    else if (high_byte_read)
      locked <= 1'b0;
    else if (low_byte_read)
      locked <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      result <= '0;
    else if (finish && !locked)
      result <= adj_word;
  end

  // hardware set wins over software clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      conversion_done_flag <= 1'b0;
    else if (finish)
      conversion_done_flag <= 1'b1;
    else if (done_flag_clear)
      conversion_done_flag <= 1'b0;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conversion_done_pulse <= 1'b0;
      sample_strobe         <= 1'b0;
    end else begin
      conversion_done_pulse <= finish;
      // a free-running restart is a new conversion too, so it strobes as well
      sample_strobe         <= ((state != SAC_CONV) && (next_state == SAC_CONV)) || restart;
    end
  end

  assign start_conversion_bit = busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  lock_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (locked && !high_byte_read) |=> $stable(result))
    else $error("result changed while locked");
  flag_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    finish |=> conversion_done_flag)
    else $error("done flag not set on completion");
  start_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !free_run && powered) |=> !start_conversion_bit)
    else $error("start bit not cleared after single conversion");
  free_run_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && free_run && powered) |=> start_conversion_bit)
    else $error("free running did not restart");
  chan_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_CONV && $past(state) == SAC_CONV && !$past(finish))
      |-> $stable(active_channel))
    else $error("channel changed mid conversion");
  presc_rst_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !powered |=> presc == 8'h00)
    else $error("prescaler ran while disabled");
  trig_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    trig_start |=> (state == SAC_CONV) && (presc == 8'h00))
    else $error("trigger edge did not start conversion");
  unlock_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    high_byte_read |=> !locked)
    else $error("high byte read did not unlock");
  busy_read_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_CONV) |-> start_conversion_bit)
    else $error("start bit low during conversion");
  adjust_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !locked && !cfg.left_adjust_select) |=> result[15:10] == 6'h00)
    else $error("right adjust upper bits not zero");

  // ------------------------------------------------------------
  // sequencing checks
  // ------------------------------------------------------------
  sw_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sw_start && !trig_start) |=> state == SAC_WAIT)
    else $error("software start did not enter wait");
  hold_wait_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_WAIT && powered && !presc_tick) |=> state == SAC_WAIT)
    else $error("wait left before converter tick");
  wait_tick_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_WAIT && powered && presc_tick) |=> state == SAC_CONV)
    else $error("wait did not start on converter tick");
  busy_ignore_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (busy && trig_edge && !presc_tick) |=> presc == $past(presc) + 8'h01)
    else $error("trigger edge disturbed a running conversion");
  level_no_restart_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_IDLE && trig_sel && trig_prev && !start_write) |=> state == SAC_IDLE)
    else $error("trigger level started a conversion");
  first_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (powered && !en_prev) |=> first_pending)
    else $error("long first conversion not armed");
  first_clr_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    finish |=> !first_pending)
    else $error("long first conversion repeated");
  cnt_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_CONV && presc_tick && !finish && powered) |=> cyc == $past(cyc) + 5'd1)
    else $error("cycle count missed a converter tick");
  cyc_max_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_CONV) |-> cyc < `SAC_CYC_FIRST)
    else $error("conversion ran past its length");
  lock_set_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (low_byte_read && !high_byte_read) |=> locked)
    else $error("low byte read did not lock");
  result_upd_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !locked) |=> result == $past(adj_word))
    else $error("result not written on completion");
  right_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !locked && !cfg.left_adjust_select) |=> result[9:0] == $past(core_sample))
    else $error("right adjusted sample misplaced");
  left_adj_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (finish && !locked && cfg.left_adjust_select) |=> result[15:6] == $past(core_sample))
    else $error("left adjusted sample misplaced");
  pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    finish |=> conversion_done_pulse)
    else $error("done pulse missing after completion");
  flag_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (done_flag_clear && !finish) |=> !conversion_done_flag)
    else $error("done flag not cleared");
  sel_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !powered |=> $stable(active_channel) && $stable(active_reference))
    else $error("selection applied while disabled");
  off_idle_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !powered |=> state == SAC_IDLE)
    else $error("conversion kept running while disabled");
  free_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == SAC_IDLE && free_run && !start_write) |=> state == SAC_IDLE)
    else $error("free running began without software start");
  sw_auto_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (sw_start && cfg.auto_trigger_enable && !trig_start) |=> start_conversion_bit)
    else $error("software start ignored under auto trigger");
  strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((state == SAC_CONV && $past(state) != SAC_CONV) || $past(restart)) |-> sample_strobe)
    else $error("sample strobe missing at conversion start");
endmodule : sac_conv_ctrl
`default_nettype wire

//--- sac_core_model.sv
// behavioural converter core that answers the control block
`timescale 1ns/10ps
`default_nettype none
module sac_core_model (
  input  wire logic [3:0] active_channel,
  output logic      [9:0] core_sample
);
  // value names the locked channel, so a result shows which input was used
  assign core_sample = {active_channel, 6'h15};
endmodule : sac_core_model
`default_nettype wire

//--- tb.sv
// self-checking bench for the conversion control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  import sac_pkg::*;
  logic        clk_sys, rst_n, pr, sw, dfc, lrd, hrd;
  sac_cfg_t    cfg;
  logic [7:0]  trg;
  logic [9:0]  smp;
  logic        sbit, flag, dpl, sstb;
  sac_result_t res;
  logic [3:0]  ach;
  logic [1:0]  reference_pin;
  int          err_total, samples_checked, cyc, d1, d2, n, ns;
  sac_conv_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .cfg(cfg),
    .converter_power_reduction(pr), .start_write(sw), .done_flag_clear(dfc),
    .low_byte_read(lrd), .high_byte_read(hrd), .trigger_lines(trg),
    .core_sample(smp), .start_conversion_bit(sbit), .conversion_done_flag(flag),
    .conversion_done_pulse(dpl), .result(res), .active_channel(ach),
    .active_reference(reference_pin), .sample_strobe(sstb));
  sac_core_model core (.active_channel(ach), .core_sample(smp));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_sim;
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // k: 0 start, 1 flag clear, 2 low read, 3 high read
  task automatic pls(input int k);
    @(posedge clk_sys);
    {sw, dfc, lrd, hrd} <= 4'h8 >> k;
    @(posedge clk_sys);
    {sw, dfc, lrd, hrd} <= 4'h0;
    #1;
  endtask : pls
  task automatic wt(output int c);
    c = 0;
    do begin
      @(posedge clk_sys);
      #1;
      c++;
      ns += sstb;
    end while (dpl !== 1'b1 && c < 300);
    if (c >= 300) chk(16'h0, 16'h1);
  endtask : wt
  function automatic logic [15:0] ex(input logic [3:0] c, input logic l);
    ex = l ? {c, 6'h15, 6'h00} : {6'h00, c, 6'h15};
  endfunction : ex
  // hang guard: full run is well under 3000 cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    pr = 1'b1;
    {sw, dfc, lrd, hrd} = 4'h0;
    trg = 8'h00;
    cfg = '0;
    cfg.input_channel_select = 4'h3;
    cfg.reference_select = 2'h1;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    pr <= 1'b0;
    pls(0);
    repeat (40) @(posedge clk_sys);
    chk({sbit, flag, reference_pin, ach}, 16'h0);
    @(posedge clk_sys);
    cfg.converter_enable <= 1'b1;
    pls(0);
    chk(sbit, 16'h1);
    wt(d1);
    chk({sbit, flag}, 16'h1);
    chk(res, ex(4'h3, 1'b0));
    chk(reference_pin, 16'h1);
    chk(ns, 16'h1);
    pls(1);
    chk(flag, 16'h0);
    pls(0);
    wt(d2);
    chk(16'(d1 - d2), 16'd12);
    chk(d2 >= 13, 16'h1);
    @(posedge clk_sys);
    cfg.left_adjust_select <= 1'b1;
    cfg.input_channel_select <= 4'he;
    pls(0);
    wt(d1);
    chk(res, ex(4'he, 1'b1));
    pls(1);
    pls(2);
    cfg.input_channel_select <= 4'h5;
    pls(0);
    wt(d1);
    chk(res, ex(4'he, 1'b1));
    chk(flag, 16'h1);
    pls(3);
    pls(0);
    wt(d1);
    chk(res, ex(4'h5, 1'b1));
    @(posedge clk_sys);
    cfg.left_adjust_select <= 1'b0;
    cfg.input_channel_select <= 4'h3;
    pls(0);
    repeat (4) @(posedge clk_sys);
    cfg.input_channel_select <= 4'h7;
    wt(d1);
    chk(res, ex(4'h3, 1'b0));
    cfg.auto_trigger_enable <= 1'b1;
    cfg.trigger_source_select <= 3'h2;
    cfg.prescale_div <= 8'h01;
    repeat (2) @(posedge clk_sys);
    trg <= 8'h04;
    repeat (3) @(posedge clk_sys);
    trg <= 8'h00;
    @(posedge clk_sys);
    trg <= 8'h04;
    wt(d1);
    chk(res, ex(4'h7, 1'b0));
    trg <= 8'h24;
    n = 0;
    repeat (60) begin
      @(posedge clk_sys);
      #1;
      n += dpl;
    end
    chk(n, 16'h0);
    pls(0);
    wt(d1);
    chk(sbit, 16'h0);
    trg <= 8'h00;
    cfg.trigger_source_select <= 3'h0;
    pls(0);
    wt(d1);
    chk({sbit, sstb}, 16'h3);
    wt(d2);
    chk({sbit, flag}, 16'h3);
    end_sim();
  end
endmodule : tb
`default_nettype wire
